// *** core/fdcpc_params.svh ***
// constants for the dual clock fifo port control block
`ifndef FDCPC_PARAMS_SVH
`define FDCPC_PARAMS_SVH

`define FDCPC_DATA_W 36
`define FDCPC_CFG_W 8
`define FDCPC_DEPTH_LOG2 10
`define FDCPC_NUM_CFG 4
`define FDCPC_CFG_IDX_W 2
`define FDCPC_CFG_DEFAULT 8'h00
`define FDCPC_SYNC_STAGES 3
`define FDCPC_WSEL_W 3
`define FDCPC_WIDTH_CODE_W 6

// word width select codes, in bits
`define FDCPC_WIDTH_X9 6'h09
`define FDCPC_WIDTH_X12 6'h0C
`define FDCPC_WIDTH_X16 6'h10
`define FDCPC_WIDTH_X18 6'h12
`define FDCPC_WIDTH_X20 6'h14
`define FDCPC_WIDTH_X24 6'h18
`define FDCPC_WIDTH_X32 6'h20
`define FDCPC_WIDTH_X36 6'h24

`endif

// *** core/fdcpc_pkg.sv ***
// types shared by the fifo port control files
package fdcpc_pkg;
  typedef enum logic [2:0] {
    fdcpc_ws_x9, fdcpc_ws_x12, fdcpc_ws_x16, fdcpc_ws_x18,
    fdcpc_ws_x20, fdcpc_ws_x24, fdcpc_ws_x32, fdcpc_ws_x36
  } fdcpc_wsel_t;
  typedef enum logic [1:0] {
    fdcpc_tgt_none, fdcpc_tgt_cfg, fdcpc_tgt_mem, fdcpc_tgt_mbox
  } fdcpc_target_t;
endpackage

// *** core/fdcpc_mem.sv ***
// fifo storage array, one write port and one unregistered read port
`timescale 1ns/1ps
module fdcpc_mem #(
  parameter int DATA_W = 36,
  parameter int ADDR_W = 10
) (
  input wire logic i_core_clk,
  input wire logic i_we,
  input wire logic [ADDR_W-1:0] i_waddr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic [ADDR_W-1:0] i_raddr,
  output logic [DATA_W-1:0] o_rdata
);
  // no reset: contents only matter once written
  logic [DATA_W-1:0] mem_ff [0:(1<<ADDR_W)-1];

  always_ff @(posedge i_core_clk) begin
    if (i_we) begin
      mem_ff[i_waddr] <= i_wdata;
    end
  end

  assign o_rdata = mem_ff[i_raddr];
endmodule

// *** core/fdcpc_cfg_regs.sv ***
// configuration register bank loaded and read in sequence
`timescale 1ns/1ps
`include "fdcpc_params.svh"
module fdcpc_cfg_regs #(
  parameter int NUM_CFG = `FDCPC_NUM_CFG,
  parameter int IDX_W = `FDCPC_CFG_IDX_W,
  parameter int CFG_W = `FDCPC_CFG_W
) (
  input wire logic i_core_clk,
  input wire logic i_load_defaults,
  input wire logic i_index_clear,
  input wire logic i_wr,
  input wire logic [CFG_W-1:0] i_wdata,
  input wire logic i_rd,
  output logic [CFG_W-1:0] o_rdata
);
  logic [CFG_W-1:0] cfg_ff [0:NUM_CFG-1];
  logic [IDX_W-1:0] widx_ff;
  logic [IDX_W-1:0] ridx_ff;
  logic [IDX_W-1:0] nxt_widx;
  logic [IDX_W-1:0] nxt_ridx;

  // both indices wrap so the bank is loaded as a ring
  assign nxt_widx = i_wr ? widx_ff + 1'b1 : widx_ff;
  assign nxt_ridx = i_rd ? ridx_ff + 1'b1 : ridx_ff;
  assign o_rdata = cfg_ff[ridx_ff];

  always_ff @(posedge i_core_clk) begin
    if (i_load_defaults || i_index_clear) begin
      widx_ff <= '0;
      ridx_ff <= '0;
    end else begin
      widx_ff <= nxt_widx;
      ridx_ff <= nxt_ridx;
    end
  end

  // partial clear only rewinds the indices, contents survive [RL3]
  always_ff @(posedge i_core_clk) begin
    for (int i = 0; i < NUM_CFG; i++) begin
      if (i_load_defaults) begin
        cfg_ff[i] <= `FDCPC_CFG_DEFAULT; // [RL2]
      end else if (i_wr && (widx_ff == IDX_W'(i))) begin
        cfg_ff[i] <= i_wdata;
      end
    end
  end
endmodule

// *** core/fdcpc_port_ctrl.sv ***
// write and read port control of the dual clock fifo
`timescale 1ns/1ps
`include "fdcpc_params.svh"
// Overview of operation
// RL1: either clear zeroes pointers, flags and the output register.
// RL2: master clear also returns configuration registers to defaults.
// RL3: partial clear keeps configuration contents, clears pointers, flags, output.
// RL4: one three-bit width select sets word size for both ports.
// RL5: load target low moves low byte to config; high moves full word.
// RL6: write strobe low captures input word every clock into selected target.
// RL7: every enabled write advances pointer; memory written only with gate low. A write while full is dropped and does not advance it.
// RL8: read strobe low fetches one word every clock from selected target.
// RL9: output word driven only while drive enable low, else released.
// RL10: active-low output valid marks valid read data on the output.
// RL11: replay tag records location of the word now on the output.
// RL12: reader pulses replay request; read pointer reloads the marked location.
// RL13: after replay, reads return earlier data in order until empty.
// RL14: mailbox select routes writes and reads through the mailbox register.
// RL15: empty indicator low when fifo empty, updated on the read side.
// RL16: data buses up to 36 bits, only selected width used.
// RL17: writer performs even write counts, minimum two; reads any count.
// RL18: full indicator low when fifo full, updated on the write side.
// RL19: pointers cross to the opposite side before flags compare them.
module fdcpc_port_ctrl #(
  parameter int DATA_W = `FDCPC_DATA_W,
  parameter int DEPTH_LOG2 = `FDCPC_DEPTH_LOG2,
  parameter int CFG_W = `FDCPC_CFG_W
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_master_clear_in_n,
  input wire logic i_partial_clear_in_n,
  input wire logic [`FDCPC_WSEL_W-1:0] i_word_width_select,
  input wire logic i_load_target_select,
  input wire logic i_write_strobe_n,
  input wire logic i_input_gate_n,
  input wire logic [DATA_W-1:0] i_data,
  input wire logic i_read_strobe_n,
  input wire logic i_drive_enable_n,
  input wire logic i_replay_position_tag,
  input wire logic i_replay_request,
  input wire logic i_mailbox_select,
  output logic [DATA_W-1:0] o_data,
  output logic o_data_oe,
  output logic o_output_valid_n,
  output logic o_empty_indicator_n,
  output logic o_full_indicator_n
);
  localparam int PTR_W = DEPTH_LOG2 + 1;
  localparam int NSYNC = `FDCPC_SYNC_STAGES;

  // ---- clear pins: three-stage synchronisers with agreement filter
  logic [1:0] clr_pin;
  logic [1:0] clr_lvl_ff;
  assign clr_pin = {i_partial_clear_in_n, i_master_clear_in_n};

  for (genvar g = 0; g < 2; g++) begin : g_clr_sync
    logic [NSYNC-1:0] sync_ff;
    logic nxt_lvl;
    // a change only counts once the second and third stage agree
    assign nxt_lvl = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : clr_lvl_ff[g];
    always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
        sync_ff <= '1;
        clr_lvl_ff[g] <= 1'b1;
      end else begin
        sync_ff <= {sync_ff[NSYNC-2:0], clr_pin[g]};
        clr_lvl_ff[g] <= nxt_lvl;
      end
    end
  end

  logic mclr_act;
  logic pclr_act;
  logic clr_all;
  logic cfg_defaults;
  assign mclr_act = ~clr_lvl_ff[0];
  assign pclr_act = ~clr_lvl_ff[1];
  assign clr_all = ~i_nrst | mclr_act | pclr_act; // [RL1] [RL3]
  assign cfg_defaults = ~i_nrst | mclr_act; // [RL2]

  // ---- word width: one select serves both ports
  logic [`FDCPC_WIDTH_CODE_W-1:0] sel_width;
  logic [DATA_W-1:0] width_mask;
  fdcpc_pkg::fdcpc_wsel_t wsel;
  assign wsel = fdcpc_pkg::fdcpc_wsel_t'(i_word_width_select);
  assign sel_width =
    (wsel == fdcpc_pkg::fdcpc_ws_x9)  ? `FDCPC_WIDTH_X9 :
    (wsel == fdcpc_pkg::fdcpc_ws_x12) ? `FDCPC_WIDTH_X12 :
    (wsel == fdcpc_pkg::fdcpc_ws_x16) ? `FDCPC_WIDTH_X16 :
    (wsel == fdcpc_pkg::fdcpc_ws_x18) ? `FDCPC_WIDTH_X18 :
    (wsel == fdcpc_pkg::fdcpc_ws_x20) ? `FDCPC_WIDTH_X20 :
    (wsel == fdcpc_pkg::fdcpc_ws_x24) ? `FDCPC_WIDTH_X24 :
    (wsel == fdcpc_pkg::fdcpc_ws_x32) ? `FDCPC_WIDTH_X32 :
    `FDCPC_WIDTH_X36; // [RL4]
  // a shift by the full width wraps to zero, so x36 yields all ones
  assign width_mask = (DATA_W'(1) << sel_width) - DATA_W'(1); // [RL16]

  // ---- state
  logic [PTR_W-1:0] wr_ptr_ff;
  logic [PTR_W-1:0] rd_ptr_ff;
  logic [PTR_W-1:0] wr_seen_ff;
  logic [PTR_W-1:0] rd_seen_ff;
  logic [PTR_W-1:0] mark_ptr_ff;
  logic [PTR_W-1:0] out_addr_ff;
  logic [DATA_W-1:0] out_ff;
  logic [DATA_W-1:0] mbox_ff;
  logic valid_ff;
  logic empty_ff;
  logic full_ff;
  logic replay_d_ff;

  logic [PTR_W-1:0] nxt_wr_ptr;
  logic [PTR_W-1:0] nxt_rd_ptr;
  logic [PTR_W-1:0] nxt_mark_ptr;
  logic [PTR_W-1:0] nxt_out_addr;
  logic [PTR_W-1:0] nxt_fill;
  logic [DATA_W-1:0] nxt_out;
  logic [DATA_W-1:0] nxt_mbox;
  logic nxt_valid;
  logic nxt_empty;
  logic nxt_full;

  // ---- write side decode
  logic wr_go;
  logic [DATA_W-1:0] wdata_m;
  fdcpc_pkg::fdcpc_target_t wr_tgt;
  logic wr_mbox;
  logic wr_cfg;
  logic wr_fifo;
  logic mem_we;
  assign wr_go = ~i_write_strobe_n; // [RL6]
  assign wdata_m = i_data & width_mask; // [RL16]
  assign wr_tgt = !wr_go ? fdcpc_pkg::fdcpc_tgt_none :
    i_mailbox_select ? fdcpc_pkg::fdcpc_tgt_mbox :
    i_load_target_select ? fdcpc_pkg::fdcpc_tgt_mem :
    fdcpc_pkg::fdcpc_tgt_cfg; // [RL5] [RL14]
  assign wr_mbox = (wr_tgt == fdcpc_pkg::fdcpc_tgt_mbox);
  assign wr_cfg = (wr_tgt == fdcpc_pkg::fdcpc_tgt_cfg);
  // writes on a full fifo are dropped rather than overrunning the reader
  assign wr_fifo = (wr_tgt == fdcpc_pkg::fdcpc_tgt_mem) & ~full_ff;
  assign mem_we = wr_fifo & ~i_input_gate_n; // [RL7]
  assign nxt_wr_ptr = wr_fifo ? wr_ptr_ff + 1'b1 : wr_ptr_ff; // [RL7]
  assign nxt_mbox = wr_mbox ? wdata_m : mbox_ff; // [RL14]

  // ---- read side decode
  logic rd_go;
  fdcpc_pkg::fdcpc_target_t rd_tgt;
  logic rd_mbox;
  logic rd_cfg;
  logic rd_fifo;
  logic replay_rise;
  logic [DATA_W-1:0] mem_rdata;
  logic [CFG_W-1:0] cfg_rdata;
  assign rd_go = ~i_read_strobe_n; // [RL8]
  assign rd_tgt = !rd_go ? fdcpc_pkg::fdcpc_tgt_none :
    i_mailbox_select ? fdcpc_pkg::fdcpc_tgt_mbox :
    i_load_target_select ? fdcpc_pkg::fdcpc_tgt_mem :
    fdcpc_pkg::fdcpc_tgt_cfg; // [RL5] [RL14]
  assign rd_mbox = (rd_tgt == fdcpc_pkg::fdcpc_tgt_mbox);
  assign rd_cfg = (rd_tgt == fdcpc_pkg::fdcpc_tgt_cfg);
  // replay takes the pointer this cycle, so a coincident fifo read is dropped
  assign replay_rise = i_replay_request & ~replay_d_ff; // [RL12]
  assign rd_fifo = (rd_tgt == fdcpc_pkg::fdcpc_tgt_mem) & ~empty_ff & ~replay_rise;

  assign nxt_rd_ptr = replay_rise ? mark_ptr_ff :
    rd_fifo ? rd_ptr_ff + 1'b1 : rd_ptr_ff; // [RL12] [RL13]
  assign nxt_out = rd_mbox ? mbox_ff :
    rd_cfg ? {{(DATA_W-CFG_W){1'b0}}, cfg_rdata} :
    rd_fifo ? (mem_rdata & width_mask) : out_ff; // [RL5] [RL8] [RL16]
  assign nxt_out_addr = rd_fifo ? rd_ptr_ff : out_addr_ff;
  // a read that finds nothing leaves stale data, flagged as not valid
  assign nxt_valid = rd_go ? (rd_mbox | rd_cfg | rd_fifo) : valid_ff; // [RL10]
  assign nxt_mark_ptr = i_replay_position_tag ? out_addr_ff : mark_ptr_ff; // [RL11]

  // ---- flags compare against the crossed copy of the far pointer
  // the copy lags one cycle, so both flags err on the safe side
  assign nxt_empty = (wr_seen_ff == nxt_rd_ptr); // [RL15] [RL19]
  assign nxt_fill = nxt_wr_ptr - rd_seen_ff;
  assign nxt_full = nxt_fill[PTR_W-1]; // [RL18] [RL19]

  // ---- storage
  fdcpc_mem #(
    .DATA_W(DATA_W),
    .ADDR_W(DEPTH_LOG2)
  ) u_mem (
    .i_core_clk(i_core_clk),
    .i_we(mem_we),
    .i_waddr(wr_ptr_ff[DEPTH_LOG2-1:0]),
    .i_wdata(wdata_m),
    .i_raddr(rd_ptr_ff[DEPTH_LOG2-1:0]),
    .o_rdata(mem_rdata)
  );

  fdcpc_cfg_regs #(
    .CFG_W(CFG_W)
  ) u_cfg (
    .i_core_clk(i_core_clk),
    .i_load_defaults(cfg_defaults),
    .i_index_clear(clr_all),
    .i_wr(wr_cfg),
    .i_wdata(wdata_m[CFG_W-1:0]),
    .i_rd(rd_cfg),
    .o_rdata(cfg_rdata)
  ); // [RL5] [RL6] [RL8]

  // ---- pointers
  always_ff @(posedge i_core_clk) begin
    if (clr_all) begin
      wr_ptr_ff <= '0; // [RL1]
      rd_ptr_ff <= '0; // [RL1]
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (clr_all) begin
      wr_seen_ff <= '0;
      rd_seen_ff <= '0;
    end else begin
      wr_seen_ff <= wr_ptr_ff; // [RL19]
      rd_seen_ff <= rd_ptr_ff; // [RL19]
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (clr_all) begin
      mark_ptr_ff <= '0;
      out_addr_ff <= '0;
      replay_d_ff <= 1'b0;
    end else begin
      mark_ptr_ff <= nxt_mark_ptr;
      out_addr_ff <= nxt_out_addr;
      replay_d_ff <= i_replay_request;
    end
  end

  // ---- output register, valid and mailbox
  always_ff @(posedge i_core_clk) begin
    if (clr_all) begin
      out_ff <= '0; // [RL1]
      valid_ff <= 1'b0;
      mbox_ff <= '0;
    end else begin
      out_ff <= nxt_out;
      valid_ff <= nxt_valid;
      mbox_ff <= nxt_mbox;
    end
  end

  // ---- flags, cleared to the empty, not-full state
  always_ff @(posedge i_core_clk) begin
    if (clr_all) begin
      empty_ff <= 1'b1; // [RL1]
      full_ff <= 1'b0; // [RL1]
    end else begin
      empty_ff <= nxt_empty;
      full_ff <= nxt_full;
    end
  end

  // ---- pins
  assign o_data = out_ff;
  assign o_data_oe = ~i_drive_enable_n; // [RL9]
  assign o_output_valid_n = ~(valid_ff & ~i_drive_enable_n); // [RL10]
  assign o_empty_indicator_n = ~empty_ff; // [RL15]
  assign o_full_indicator_n = ~full_ff; // [RL18]
endmodule

// *** dv/fdcpc_port_ctrl_assertions.sv ***
// assertion checker for the fifo port control outputs
`timescale 1ns/1ps
module fdcpc_port_ctrl_assertions #(parameter int DATA_W = 36, DEPTH_LOG2 = 10, CFG_W = 8) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_master_clear_in_n,
  input wire logic i_partial_clear_in_n,
  input wire logic [2:0] i_word_width_select,
  input wire logic i_load_target_select,
  input wire logic i_write_strobe_n,
  input wire logic i_input_gate_n,
  input wire logic [DATA_W-1:0] i_data,
  input wire logic i_read_strobe_n,
  input wire logic i_drive_enable_n,
  input wire logic i_replay_position_tag,
  input wire logic i_replay_request,
  input wire logic i_mailbox_select,
  input wire logic [DATA_W-1:0] o_data,
  input wire logic o_data_oe,
  input wire logic o_output_valid_n,
  input wire logic o_empty_indicator_n,
  input wire logic o_full_indicator_n
);
  // clear pins pass a 3-flop sync, so the read, hold, fill and full checks wait for 7 calm edges
  logic [2:0] calm_ff;
  logic [2:0] nxt_calm;
  logic calm;
  logic fifo_rd;
  assign nxt_calm = !(i_master_clear_in_n && i_partial_clear_in_n) ? 3'h0 :
    calm_ff + 3'(calm_ff != 3'h7);
  assign calm = (calm_ff == 3'h7) && i_master_clear_in_n && i_partial_clear_in_n;
  assign fifo_rd = calm && !i_read_strobe_n && i_load_target_select && !i_mailbox_select &&
    !i_replay_request;
  always_ff @(posedge i_core_clk) begin
    calm_ff <= i_nrst ? nxt_calm : 3'h0;
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  property p_valid_gated; i_drive_enable_n |-> o_output_valid_n; endproperty
  a_valid_gated: assert property (p_valid_gated) else $error("valid while released");
  property p_empty_hold; fifo_rd && !o_empty_indicator_n && i_write_strobe_n &&
    $past(i_write_strobe_n) && $past(i_write_strobe_n, 2) |=> $stable(o_data); endproperty
  a_empty_hold: assert property (p_empty_hold) else $error("read on empty moved data");
  property p_read_valid; fifo_rd && o_empty_indicator_n |=>
    i_drive_enable_n || !o_output_valid_n; endproperty
  a_read_valid: assert property (p_read_valid) else $error("read gave no valid");
  property p_hold; calm && i_read_strobe_n |=> $stable(o_data); endproperty
  a_hold: assert property (p_hold) else $error("output moved without read");
  property p_mclear; !i_master_clear_in_n [*6] |-> o_data == '0 && o_output_valid_n &&
    !o_empty_indicator_n && o_full_indicator_n; endproperty
  a_mclear: assert property (p_mclear) else $error("master clear state wrong");
  property p_pclear; !i_partial_clear_in_n [*6] |-> o_data == '0 && o_output_valid_n &&
    !o_empty_indicator_n && o_full_indicator_n; endproperty
  a_pclear: assert property (p_pclear) else $error("partial clear state wrong");
  property p_fill; calm && o_full_indicator_n && !i_write_strobe_n && i_load_target_select &&
    !i_mailbox_select ##1 (calm && i_read_strobe_n) [*3] |-> o_empty_indicator_n; endproperty
  a_fill: assert property (p_fill) else $error("write left fifo empty");
  property p_full_hold; calm && !o_full_indicator_n && i_read_strobe_n |=>
    !o_full_indicator_n && o_empty_indicator_n; endproperty
  a_full_hold: assert property (p_full_hold) else $error("full flag lost");
endmodule
bind fdcpc_port_ctrl fdcpc_port_ctrl_assertions #(.DATA_W(DATA_W), .DEPTH_LOG2(DEPTH_LOG2),
  .CFG_W(CFG_W)) chk_u (.i_core_clk, .i_nrst, .i_master_clear_in_n, .i_partial_clear_in_n,
  .i_word_width_select, .i_load_target_select, .i_write_strobe_n, .i_input_gate_n, .i_data,
  .i_read_strobe_n, .i_drive_enable_n, .i_replay_position_tag, .i_replay_request,
  .i_mailbox_select, .o_data, .o_data_oe, .o_output_valid_n, .o_empty_indicator_n,
  .o_full_indicator_n);

// *** dv/fdcpc_host_model.sv ***
// host model that drives the write and read ports
`timescale 1ns/1ps
module fdcpc_host_model (
  input wire logic i_core_clk,
  output logic o_write_strobe_n,
  output logic o_input_gate_n,
  output logic [35:0] o_data,
  output logic o_read_strobe_n,
  output logic o_replay_request
);
  initial begin
    o_write_strobe_n = 1'b1;
    o_input_gate_n = 1'b0;
    o_data = 36'h0;
    o_read_strobe_n = 1'b1;
    o_replay_request = 1'b0;
  end
  // bursts are kept even; gate pattern repeats every 8 words
  task automatic put(input logic [35:0] w[$], input logic [7:0] g);
    @(posedge i_core_clk);
    foreach (w[i]) begin
      #1;
      o_write_strobe_n = 1'b0;
      o_input_gate_n = g[i % 8];
      o_data = w[i];
      @(posedge i_core_clk);
    end
    #1;
    o_write_strobe_n = 1'b1;
    o_data = ~o_data;
  endtask
  task automatic get();
    @(posedge i_core_clk);
    #1;
    o_read_strobe_n = 1'b0;
    @(posedge i_core_clk);
    #1;
    o_read_strobe_n = 1'b1;
  endtask
  task automatic replay();
    @(posedge i_core_clk);
    #1;
    o_replay_request = 1'b1;
    @(posedge i_core_clk);
    #1;
    o_replay_request = 1'b0;
  endtask
endmodule

// *** dv/tb_dual_clock_fifo_port_control.sv ***
// self-checking bench for the fifo port control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_dual_clock_fifo_port_control;
  logic i_core_clk = 1'b0;
  logic nrst = 1'b0;
  logic mclr_n = 1'b1;
  logic pclr_n = 1'b1;
  logic tgt_mem = 1'b1;
  logic oe_n = 1'b0;
  logic tag = 1'b0;
  logic mbox = 1'b0;
  logic [2:0] wsel = 3'h7;
  logic wr_n, gate_n, rd_n, rpl, oe, val_n, emp_n, full_n;
  logic [35:0] din, dout;
  int n_errors = 0;
  int comparisons = 0;
  always #20 i_core_clk = ~i_core_clk;
  fdcpc_host_model host_u (.i_core_clk(i_core_clk), .o_write_strobe_n(wr_n),
    .o_input_gate_n(gate_n), .o_data(din), .o_read_strobe_n(rd_n), .o_replay_request(rpl));
  fdcpc_port_ctrl #(.DATA_W(36), .DEPTH_LOG2(10), .CFG_W(8)) dut_u (.i_core_clk(i_core_clk),
    .i_nrst(nrst), .i_master_clear_in_n(mclr_n), .i_partial_clear_in_n(pclr_n),
    .i_word_width_select(wsel), .i_load_target_select(tgt_mem), .i_write_strobe_n(wr_n),
    .i_input_gate_n(gate_n), .i_data(din), .i_read_strobe_n(rd_n), .i_drive_enable_n(oe_n),
    .i_replay_position_tag(tag), .i_replay_request(rpl), .i_mailbox_select(mbox),
    .o_data(dout), .o_data_oe(oe), .o_output_valid_n(val_n), .o_empty_indicator_n(emp_n),
    .o_full_indicator_n(full_n));
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wait_for(ref logic s, input logic v);
    for (int k = 0; k < 12 && s !== v; k++) begin
      @(posedge i_core_clk);
      #1;
    end
    if (s !== v) begin
      n_errors++;
      final_report();
    end
  endtask
  // sync and agreement filter take 4 edges each way, so hold 6 and settle 5
  task automatic clr(ref logic pin);
    pin = 1'b0;
    repeat (6) @(posedge i_core_clk);
    #1;
    `CHK("clr_data", 36'h0, dout)
    `CHK("clr_empty", 1'b0, emp_n)
    `CHK("clr_full", 1'b1, full_n)
    pin = 1'b1;
    repeat (5) @(posedge i_core_clk);
    #1;
  endtask
  task automatic rd_chk(input logic [35:0] e);
    host_u.get();
    `CHK("rdata", e, dout)
  endtask
  task automatic t_stream();
    host_u.put('{36'h123456789, 36'hABCDEF012, 36'h111111111, 36'hFEDCBA987}, 8'h04);
    wait_for(emp_n, 1'b1);
    rd_chk(36'h123456789);
    `CHK("valid", 1'b0, val_n)
    oe_n = 1'b1;
    @(posedge i_core_clk);
    #1;
    `CHK("oe", 1'b0, oe)
    `CHK("valid_off", 1'b1, val_n)
    oe_n = 1'b0;
    #1;
    `CHK("oe_on", 1'b1, oe)
    rd_chk(36'hABCDEF012);
    host_u.get();
    rd_chk(36'hFEDCBA987);
    `CHK("empty", 1'b0, emp_n)
    $display("test stream done");
  endtask
  task automatic t_width();
    int wid[8] = '{9, 12, 16, 18, 20, 24, 32, 36};
    logic [35:0] m;
    for (int c = 0; c < 8; c++) begin
      wsel = 3'(c);
      m = (36'h1 << wid[c]) - 36'h1;
      host_u.put('{36'hFFFFFFFFF, 36'hA5A5A5A5A}, 8'h00);
      wait_for(emp_n, 1'b1);
      rd_chk(36'hFFFFFFFFF & m);
      rd_chk(36'hA5A5A5A5A & m);
    end
    $display("test width done");
  endtask
  task automatic t_replay();
    host_u.put('{36'h0A0A0A0A0, 36'h0B0B0B0B0, 36'h0C0C0C0C0, 36'h0D0D0D0D0}, 8'h00);
    wait_for(emp_n, 1'b1);
    rd_chk(36'h0A0A0A0A0);
    tag = 1'b1;
    @(posedge i_core_clk);
    #1;
    tag = 1'b0;
    rd_chk(36'h0B0B0B0B0);
    host_u.replay();
    rd_chk(36'h0A0A0A0A0);
    rd_chk(36'h0B0B0B0B0);
    rd_chk(36'h0C0C0C0C0);
    rd_chk(36'h0D0D0D0D0);
    `CHK("empty", 1'b0, emp_n)
    $display("test replay done");
  endtask
  task automatic t_mbox_cfg();
    mbox = 1'b1;
    host_u.put('{36'h0F0F0F0F0, 36'h123123123}, 8'h00);
    rd_chk(36'h123123123);
    mbox = 1'b0;
    `CHK("empty", 1'b0, emp_n)
    tgt_mem = 1'b0;
    host_u.put('{36'hFFFFFFFA5, 36'hFFFFFFF3C}, 8'h00);
    clr(pclr_n);
    rd_chk(36'h0000000A5);
    rd_chk(36'h00000003C);
    clr(mclr_n);
    rd_chk(36'h000000000);
    tgt_mem = 1'b1;
    $display("test mailbox config done");
  endtask
  task automatic t_full();
    logic [35:0] q[$];
    for (int i = 0; i < 1024; i++) begin
      q.push_back(36'(i));
    end
    host_u.put(q, 8'h00);
    wait_for(full_n, 1'b0);
    host_u.put('{36'h00000BAD0, 36'h00000BAD1}, 8'h00);
    rd_chk(36'h000000000);
    clr(pclr_n);
    $display("test full done");
  endtask
  initial begin
    repeat (20) @(posedge i_core_clk);
    #1;
    nrst = 1'b1;
    @(posedge i_core_clk);
    #1;
    `CHK("rst_empty", 1'b0, emp_n)
    `CHK("rst_full", 1'b1, full_n)
    `CHK("rst_data", 36'h0, dout)
    t_stream();
    t_width();
    t_replay();
    t_mbox_cfg();
    t_full();
    final_report();
  end
endmodule
